// File: lks_ctrl.sv
// Top module: sleep gating, key scan sequencing, read request and system reset control
// ****************************************
// ****************************************
module lks_ctrl #(
   parameter int OSC_DIV = lks_pkg::OSC_DIV_DEF
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RD_DATA,
   // Pins from outside
   input wire logic TRANSFER_ENABLE,
   input wire logic SUPPLY_DETECT_RESET,
   input wire logic EXT_CLOCK,
   input wire logic [4:0] RETURN_INPUTS,
   // Key read request, open drain
   output logic SERIAL_OUT_O,
   output logic SERIAL_OUT_OE_N,
   // Scan and shared pins
   output logic [5:0] SCAN_OUTPUTS,
   output logic [3:0] PORT_ENABLE,
   output logic [3:0] PORT_VALUE,
   // Display and clock control
   output logic DISPLAY_ON,
   output logic FOURTH_COMMON_IS_COMMON,
   output logic OSC_RUN,
   output logic OSC_PIN_HIZ,
   output logic FRAME_TICK
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [lks_pkg::PIN_W-1:0] pin_raw;
   logic [lks_pkg::PIN_W-1:0] pin_s1;
   logic [lks_pkg::PIN_W-1:0] pin_s2;
   logic [lks_pkg::PIN_W-1:0] pin_s3;
   logic [lks_pkg::PIN_W-1:0] pin;
   logic [lks_pkg::PIN_W-1:0] pin_d;

   assign pin_raw = {RETURN_INPUTS, EXT_CLOCK, SUPPLY_DETECT_RESET, TRANSFER_ENABLE};

   always_ff @(posedge CLK) begin
      if (SRST) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // A change is taken only once the last two stages agree
   genvar gp;
   generate
      for (gp = 0; gp < lks_pkg::PIN_W; gp++) begin : g_pin
         always_ff @(posedge CLK) begin
            if (SRST) begin
               pin[gp] <= 1'b0;
               pin_d[gp] <= 1'b0;
            end else begin
               if (pin_s2[gp] == pin_s3[gp]) begin
                  pin[gp] <= pin_s3[gp];
               end
               pin_d[gp] <= pin[gp];
            end
         end
      end
   endgenerate

   logic ce;
   logic ce_fall;
   logic supply_detect_reset;
   logic ext_rise;
   logic [4:0] ret;

   assign ce = pin[lks_pkg::PIN_CE];
   assign ce_fall = pin_d[lks_pkg::PIN_CE] & ~pin[lks_pkg::PIN_CE];
   assign supply_detect_reset = pin[lks_pkg::PIN_SUPPLY_DETECT_RESET];
   assign ext_rise = pin[lks_pkg::PIN_EXTCLK] & ~pin_d[lks_pkg::PIN_EXTCLK];
   assign ret = pin[lks_pkg::PIN_RET +: lks_pkg::RETURN_LINES];

   // ****************************************
   // Control register
   // ****************************************
   lks_pkg::lks_ctrl_t ctrl;
   logic ctrl_wr;
   logic key_rd;
   logic duty_loaded;

   assign ctrl_wr = WR && (ADDR == lks_pkg::CTRL_OFS);
   assign key_rd = RD && (ADDR == lks_pkg::KEY_OFS);

   // Only SRST touches the serial-facing state, never the system reset
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl <= lks_pkg::lks_ctrl_t'(lks_pkg::CTRL_RESET);
      end else if (ctrl_wr) begin
         ctrl <= lks_pkg::lks_ctrl_t'(WR_DATA[lks_pkg::CTRL_W-1:0]);
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         duty_loaded <= 1'b0;
      end else if (ctrl_wr) begin
         duty_loaded <= 1'b1;
      end
   end

   // ****************************************
   // System reset from the supply detector
   // ****************************************
   logic sys_rst;
   logic ctrl_seen;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl_seen <= 1'b0;
      end else if (supply_detect_reset) begin
         ctrl_seen <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_seen <= 1'b1;
      end
   end

   // Held until the transfer that completes loading ends
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sys_rst <= 1'b1;
      end else if (supply_detect_reset) begin
         sys_rst <= 1'b1;
      end else if (ce_fall && ctrl_seen) begin
         sys_rst <= 1'b0;
      end
   end

   // ****************************************
   // Oscillator period tick
   // ****************************************
   lks_pkg::lks_state_t state;
   logic scanning;
   logic osc_run;
   logic tick;
   logic [12:0] div_cnt;
   logic div_wrap;

   assign scanning = (state == lks_pkg::ST_PASS1) || (state == lks_pkg::ST_PASS2) ||
                     (state == lks_pkg::ST_SETTLE);
   assign osc_run = ~sys_rst & (~ctrl.sleep_select | scanning);
   assign div_wrap = (div_cnt == 13'(OSC_DIV - 1));
   assign tick = osc_run & (ctrl.clock_source_select ? ext_rise : div_wrap);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         div_cnt <= '0;
      end else if (!osc_run || ctrl.clock_source_select || div_wrap) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 13'h0001;
      end
   end

   // ****************************************
   // Frame clock divider
   // ****************************************
   function automatic logic [9:0] frame_div(input logic [2:0] code);
      case (code)
         3'h0: frame_div = lks_pkg::DIV_768;
         3'h1: frame_div = lks_pkg::DIV_576;
         3'h2: frame_div = lks_pkg::DIV_384;
         3'h3: frame_div = lks_pkg::DIV_288;
         3'h4: frame_div = lks_pkg::DIV_288;
         3'h5: frame_div = lks_pkg::DIV_192;
         default: frame_div = lks_pkg::DIV_768;
      endcase
   endfunction : frame_div

   logic [9:0] frame_cnt;
   logic [2:0] frame_code;
   logic frame_bad;

   // Bit order on the wire is first bit most significant
   assign frame_code = ctrl.frame_rate_bits;
   assign frame_bad = (frame_code > 3'h5);

   always_ff @(posedge CLK) begin
      if (SRST || sys_rst) begin
         frame_cnt <= '0;
         FRAME_TICK <= 1'b0;
      end else begin
         FRAME_TICK <= 1'b0;
         if (tick) begin
            if (frame_cnt >= frame_div(frame_code) - 10'h001) begin
               frame_cnt <= '0;
               FRAME_TICK <= 1'b1;
            end else begin
               frame_cnt <= frame_cnt + 10'h001;
            end
         end
      end
   end

   // ****************************************
   // Key scan sequencer
   // ****************************************
   logic [5:0] level;
   logic [5:0] slot_cnt;
   logic [2:0] line_idx;
   logic [9:0] total_cnt;
   logic [29:0] samp;
   logic [29:0] first;
   logic agree;
   logic [29:0] keys;
   logic slot_end;
   logic pass_end;
   logic pressed;

   // Line i is high when its index reaches the level code
   genvar gl;
   generate
      for (gl = 0; gl < lks_pkg::SCAN_LINES; gl++) begin : g_level
         assign level[gl] = (ctrl.scan_line_level_bits <= 3'(gl));
      end
   endgenerate

   // Return inputs see only lines that are held high
   assign pressed = |ret;
   assign slot_end = tick && (slot_cnt == 6'(lks_pkg::SLOT_T - 1));
   assign pass_end = slot_end && (line_idx == 3'(lks_pkg::SCAN_LINES - 1));

   always_ff @(posedge CLK) begin
      if (SRST || sys_rst) begin
         state <= lks_pkg::ST_IDLE;
      end else if (ctrl.scan_disable_bit) begin
         state <= lks_pkg::ST_IDLE;
      end else begin
         case (state)
            lks_pkg::ST_IDLE: begin
               if (pressed) begin
                  state <= lks_pkg::ST_PASS1;
               end
            end
            lks_pkg::ST_PASS1: begin
               if (pass_end) begin
                  state <= lks_pkg::ST_PASS2;
               end
            end
            lks_pkg::ST_PASS2: begin
               if (pass_end) begin
                  state <= lks_pkg::ST_SETTLE;
               end
            end
            lks_pkg::ST_SETTLE: begin
               if (tick && total_cnt == 10'(lks_pkg::REQUEST_T - 1)) begin
                  if (agree && |first) begin
                     state <= lks_pkg::ST_REQUEST;
                  end else if (pressed) begin
                     state <= lks_pkg::ST_PASS1;
                  end else begin
                     state <= lks_pkg::ST_IDLE;
                  end
               end
            end
            lks_pkg::ST_REQUEST: begin
               if (key_rd) begin
                  state <= lks_pkg::ST_PASS1;
               end
            end
            default: begin
               state <= lks_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Slot and pass counters clear whenever the sequencer is not scanning
   always_ff @(posedge CLK) begin
      if (SRST || sys_rst || !scanning) begin
         slot_cnt <= '0;
         line_idx <= '0;
         total_cnt <= '0;
      end else if (tick) begin
         total_cnt <= total_cnt + 10'h001;
         if (slot_end) begin
            slot_cnt <= '0;
            line_idx <= pass_end ? 3'h0 : line_idx + 3'h1;
         end else begin
            slot_cnt <= slot_cnt + 6'h01;
         end
      end
   end

   // Each crossing of a line and a return input is one key bit
   always_ff @(posedge CLK) begin
      if (SRST || sys_rst) begin
         samp <= '0;
         first <= '0;
         agree <= 1'b0;
      end else if (slot_end && scanning) begin
         samp[line_idx * 5 +: 5] <= ret & {5{level[line_idx]}};
         if (pass_end && state == lks_pkg::ST_PASS1) begin
            first <= {ret & {5{level[line_idx]}}, samp[24:0]};
         end
         if (pass_end && state == lks_pkg::ST_PASS2) begin
            agree <= ({ret & {5{level[line_idx]}}, samp[24:0]} == first);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || sys_rst) begin
         keys <= '0;
      end else if (ctrl.scan_disable_bit && state == lks_pkg::ST_REQUEST) begin
         keys <= '0;
      end else if (state == lks_pkg::ST_SETTLE && tick &&
                   total_cnt == 10'(lks_pkg::REQUEST_T - 1) && agree) begin
         keys <= first;
      end
   end

   // ****************************************
   // Read request line
   // ****************************************
   logic req_drive;

   // Released whenever a transfer is in progress or reset is applied
   assign req_drive = (state == lks_pkg::ST_REQUEST) && ~ce && ~sys_rst;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         SERIAL_OUT_O <= 1'b0;
         SERIAL_OUT_OE_N <= 1'b1;
      end else begin
         SERIAL_OUT_O <= 1'b0;
         SERIAL_OUT_OE_N <= ~req_drive;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   logic [5:0] next_scan;
   logic [3:0] next_port_en;

   always_comb begin
      next_scan = level;
      if (sys_rst) begin
         next_scan = '0;
      end else if (state == lks_pkg::ST_PASS1 || state == lks_pkg::ST_PASS2) begin
         next_scan = level & (6'h01 << line_idx);
      end
   end

   genvar gs;
   generate
      for (gs = 0; gs < lks_pkg::SHARED_PINS; gs++) begin : g_shared
         assign next_port_en[gs] = ~sys_rst && (ctrl.port_function_bits > 3'(gs));
      end
   endgenerate

   always_ff @(posedge CLK) begin
      if (SRST) begin
         SCAN_OUTPUTS <= '0;
         PORT_ENABLE <= '0;
         PORT_VALUE <= '0;
         DISPLAY_ON <= 1'b0;
         FOURTH_COMMON_IS_COMMON <= 1'b1;
         OSC_RUN <= 1'b0;
         OSC_PIN_HIZ <= 1'b1;
      end else begin
         SCAN_OUTPUTS <= next_scan;
         PORT_ENABLE <= next_port_en;
         PORT_VALUE <= next_port_en & ctrl.port_data;
         DISPLAY_ON <= ~sys_rst & ~ctrl.sleep_select;
         FOURTH_COMMON_IS_COMMON <= duty_loaded ? ctrl.duty_select_bit : 1'b1;
         OSC_RUN <= osc_run;
         OSC_PIN_HIZ <= sys_rst;
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   always_ff @(posedge CLK) begin
      if (SRST) begin
         RD_DATA <= '0;
      end else if (RD) begin
         if (ADDR == lks_pkg::CTRL_OFS) begin
            RD_DATA <= {15'h0000, ctrl};
         end else if (ADDR == lks_pkg::KEY_OFS) begin
            RD_DATA <= {1'b0, ctrl.sleep_select, keys};
         end else if (ADDR == lks_pkg::STAT_OFS) begin
            RD_DATA <= {28'h0000000, scanning, frame_bad,
                        (state == lks_pkg::ST_REQUEST), sys_rst};
         end else begin
            RD_DATA <= '0;
         end
      end
   end

endmodule : lks_ctrl

// File: lks_ctrl_assertions.sv
// Checker: port-level properties of the key scan and sleep/reset control block
module lks_ctrl_assertions #(
   parameter int OSC_DIV = lks_pkg::OSC_DIV_DEF
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RD_DATA,
   // Pins
   input wire logic TRANSFER_ENABLE,
   input wire logic SUPPLY_DETECT_RESET,
   input wire logic EXT_CLOCK,
   input wire logic [4:0] RETURN_INPUTS,
   input wire logic SERIAL_OUT_O,
   input wire logic SERIAL_OUT_OE_N,
   input wire logic [5:0] SCAN_OUTPUTS,
   input wire logic [3:0] PORT_ENABLE,
   input wire logic [3:0] PORT_VALUE,
   input wire logic DISPLAY_ON,
   input wire logic FOURTH_COMMON_IS_COMMON,
   input wire logic OSC_RUN,
   input wire logic OSC_PIN_HIZ,
   input wire logic FRAME_TICK
);
   // ****************************************
   // Shadow of the control fields we judge by
   // ****************************************
   logic sleep_q;
   logic [2:0] lvl_q;
   logic wrote_ctrl;
   logic ctrl_wr;
   assign ctrl_wr = WR && (ADDR == lks_pkg::CTRL_OFS);
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sleep_q <= 1'b0;
         lvl_q <= 3'h0;
         wrote_ctrl <= 1'b0;
      end else if (ctrl_wr) begin
         sleep_q <= WR_DATA[0];
         lvl_q <= WR_DATA[7:5];
         wrote_ctrl <= 1'b1;
      end
   end
   // Lines at index k and above are high; codes 6 and 7 leave none high
   function automatic logic [5:0] hi_mask(input logic [2:0] k);
      logic [5:0] m;
      m = 6'h3F << k;
      return m;
   endfunction : hi_mask

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // ****************************************
   // Properties
   // ****************************************
   a_sleep_blank: assert property (sleep_q && $past(sleep_q) |-> !DISPLAY_ON)
      else $error("display active in sleep");
   a_wake_display: assert property (!sleep_q && !$past(sleep_q) && !OSC_PIN_HIZ
      && !$past(OSC_PIN_HIZ) && !$past(OSC_PIN_HIZ, 2) |-> DISPLAY_ON)
      else $error("display off in normal mode");
   a_scan_low_line: assert property ($past(lvl_q) == lvl_q && $past(lvl_q, 2) == lvl_q
      |-> (SCAN_OUTPUTS & ~hi_mask(lvl_q)) == 6'h00)
      else $error("scan pulse on a line set low");
   a_ce_release: assert property (TRANSFER_ENABLE [*7] |-> SERIAL_OUT_OE_N)
      else $error("request line driven during transfer");
   a_read_clears: assert property (RD && ADDR == lks_pkg::KEY_OFS && !SERIAL_OUT_OE_N
      && !OSC_PIN_HIZ |-> ##2 SERIAL_OUT_OE_N)
      else $error("key read did not clear request");
   a_disable_clears: assert property (ctrl_wr && WR_DATA[8] |-> ##3 SERIAL_OUT_OE_N [*4])
      else $error("scan disable left request pending");
   a_reset_quiet: assert property (OSC_PIN_HIZ && $past(OSC_PIN_HIZ) |-> !DISPLAY_ON
      && SCAN_OUTPUTS == 6'h00 && PORT_ENABLE == 4'h0 && PORT_VALUE == 4'h0)
      else $error("pins active during system reset");
   a_reset_no_req: assert property (OSC_PIN_HIZ && $past(OSC_PIN_HIZ) |-> SERIAL_OUT_OE_N)
      else $error("request line low during system reset");
   a_tick_needs_osc: assert property (FRAME_TICK |-> OSC_RUN || $past(OSC_RUN))
      else $error("frame tick with clock stopped");
   a_fourth_common: assert property (!wrote_ctrl |-> FOURTH_COMMON_IS_COMMON)
      else $error("fourth common left common function early");

   c_request: cover property ($fell(SERIAL_OUT_OE_N));
   c_sleep_request: cover property (sleep_q && !SERIAL_OUT_OE_N);
   c_frame_tick: cover property (FRAME_TICK && !sleep_q);
endmodule : lks_ctrl_assertions

bind lks_ctrl lks_ctrl_assertions #(.OSC_DIV(OSC_DIV)) u_chk (.CLK(CLK), .SRST(SRST),
   .ADDR(ADDR), .WR_DATA(WR_DATA), .WR(WR), .RD(RD), .RD_DATA(RD_DATA),
   .TRANSFER_ENABLE(TRANSFER_ENABLE), .SUPPLY_DETECT_RESET(SUPPLY_DETECT_RESET),
   .EXT_CLOCK(EXT_CLOCK), .RETURN_INPUTS(RETURN_INPUTS), .SERIAL_OUT_O(SERIAL_OUT_O),
   .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .SCAN_OUTPUTS(SCAN_OUTPUTS), .PORT_ENABLE(PORT_ENABLE),
   .PORT_VALUE(PORT_VALUE), .DISPLAY_ON(DISPLAY_ON),
   .FOURTH_COMMON_IS_COMMON(FOURTH_COMMON_IS_COMMON), .OSC_RUN(OSC_RUN),
   .OSC_PIN_HIZ(OSC_PIN_HIZ), .FRAME_TICK(FRAME_TICK));

// File: lks_ctrl_tb_top.sv
// Testbench: register port, key matrix and transfer frames around the control block
module lks_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC = 4;
   localparam int REQ = lks_pkg::REQUEST_T * OSC;
   logic clk = 1'b0;
   logic srst, wr, rd, supply_detect_reset, go, hold, te, so_o, so_oe_n, disp, fourth, osc_run, hiz, tick, line;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [29:0] keys;
   logic [4:0] ret;
   logic [5:0] scan;
   logic [3:0] pen, pval;
   int bad_count = 0;
   int tests_run = 0;
   int n;
   int div[6] = '{768, 576, 384, 288, 288, 192};
   logic [2:0] ec = 3'h0;

   always #2 clk = ~clk;

   // External clock: one rise per 6 cycles, high for two so the pin filter keeps it
   always @(posedge clk) begin
      ec <= (ec == 3'h5) ? 3'h0 : ec + 3'h1;
   end

   lks_ctrl #(.OSC_DIV(OSC)) dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WR_DATA(wdata),
      .WR(wr), .RD(rd), .RD_DATA(rdata), .TRANSFER_ENABLE(te), .SUPPLY_DETECT_RESET(supply_detect_reset),
      .EXT_CLOCK(ec[2]), .RETURN_INPUTS(ret), .SERIAL_OUT_O(so_o), .SERIAL_OUT_OE_N(so_oe_n),
      .SCAN_OUTPUTS(scan), .PORT_ENABLE(pen), .PORT_VALUE(pval), .DISPLAY_ON(disp),
      .FOURTH_COMMON_IS_COMMON(fourth), .OSC_RUN(osc_run), .OSC_PIN_HIZ(hiz),
      .FRAME_TICK(tick));

   lks_host_model host (.clk(clk), .frame_go(go), .hold_enable(hold), .keys_down(keys),
      .scan_outputs(scan), .serial_out_o(so_o), .serial_out_oe_n(so_oe_n),
      .transfer_enable(te), .return_inputs(ret), .serial_line(line));

   // ****************************************
   // Helpers
   // ****************************************
   // Ports always on with a fixed pattern, so sleep can show they keep running
   function automatic logic [31:0] cw(input logic sl, input logic [2:0] lvl,
                                      input logic dis, input logic [2:0] fr);
      lks_pkg::lks_ctrl_t c;
      c = '0;
      c.sleep_select = sl;
      c.scan_line_level_bits = lvl;
      c.scan_disable_bit = dis;
      c.frame_rate_bits = fr;
      c.port_function_bits = 3'h4;
      c.port_data = 4'hA;
      c.duty_select_bit = 1'b1;
      return {15'h0000, c};
   endfunction : cw

   task automatic conclude();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic in_range(input int v, input int lo, input int hi);
      tests_run++;
      if (v < lo || v > hi) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
      end
   endtask : in_range

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : idle

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg

   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rreg

   // Bounded wait for the request line; a hang ends the run
   task automatic wait_line(input logic lvl, output int c);
      c = 0;
      while (line !== lvl && c < 4000) begin
         @(posedge clk);
         #1;
         c++;
      end
      if (c >= 4000) begin
         bad_count++;
         conclude();
      end
   endtask : wait_line

   task automatic tick_gap(output int g);
      g = 0;
      do begin
         @(posedge clk);
         #1;
         g++;
      end while (tick !== 1'b1 && g < 4000);
      if (g >= 4000) begin
         bad_count++;
         conclude();
      end
   endtask : tick_gap

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      supply_detect_reset = 1'b1;
      go = 1'b0;
      hold = 1'b0;
      keys = 30'h0000_0000;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      idle(1);
      cmp({so_oe_n, disp, hiz, fourth}, 4'hB);
      supply_detect_reset <= 1'b0;
      idle(10);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0));
      rreg(lks_pkg::CTRL_OFS, d);
      cmp(d, cw(0, 0, 0, 0));
      rreg(lks_pkg::STAT_OFS, d);
      cmp(d[0], 1'b1);
      keys <= 30'h0000_2000;
      idle(3000);
      cmp(line, 1'b1);
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h0000_0000);
      idle(2);
      cmp(line, 1'b1);
      keys <= 30'h0000_0000;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      idle(60);
      rreg(lks_pkg::STAT_OFS, d);
      cmp(d[0], 1'b0);
      cmp({disp, hiz}, 2'b10);
      for (int k = 0; k < 6; k++) begin
         wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, k[2:0]));
         tick_gap(n);
         tick_gap(n);
         tick_gap(n);
         in_range(n, div[k] * OSC, div[k] * OSC);
      end
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 6));
      rreg(lks_pkg::STAT_OFS, d);
      cmp(d, 32'h0000_0004);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 3) | 32'h0000_0002);
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      in_range(n, div[3] * 6, div[3] * 6);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0) & 32'hFFFF_EFFF);
      idle(2);
      cmp(fourth, 1'b0);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0));
      keys <= 30'h0800_2000;
      wait_line(1'b0, n);
      in_range(n, REQ - 3, REQ + 24);
      rreg(lks_pkg::STAT_OFS, d);
      cmp(d, 32'h0000_0002);
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h0800_2000);
      idle(1);
      cmp(line, 1'b1);
      wait_line(1'b0, n);
      in_range(n, REQ - 6, REQ + 24);
      hold <= 1'b1;
      idle(8);
      cmp(line, 1'b1);
      hold <= 1'b0;
      idle(8);
      cmp(line, 1'b0);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 1, 0));
      idle(2);
      cmp(line, 1'b1);
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h0000_0000);
      idle(3000);
      cmp(line, 1'b1);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0));
      wait_line(1'b0, n);
      in_range(n, REQ - 3, REQ + 30);
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h0800_2000);
      idle(1000);
      rreg(lks_pkg::STAT_OFS, d);
      cmp(d, 32'h0000_0008);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 1, 0));
      idle(3000);
      cmp(line, 1'b1);
      keys <= 30'h0000_0000;
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0));
      idle(3000);
      cmp(line, 1'b1);
      wreg(lks_pkg::CTRL_OFS, cw(1, 5, 0, 0));
      idle(1000);
      cmp({disp, osc_run, scan, pen, pval}, {2'b00, 6'h20, 4'hF, 4'hA});
      keys <= 30'h0400_0001;
      idle(20);
      cmp(osc_run, 1'b1);
      wait_line(1'b0, n);
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h4400_0000);
      keys <= 30'h0000_0000;
      idle(3000);
      cmp({disp, osc_run}, 2'b00);
      wreg(lks_pkg::CTRL_OFS, cw(0, 0, 0, 0));
      idle(4);
      cmp(disp, 1'b1);
      keys <= 30'h0000_2000;
      wait_line(1'b0, n);
      supply_detect_reset <= 1'b1;
      idle(12);
      cmp({line, disp, hiz, scan, pen}, {3'b101, 6'h00, 4'h0});
      rreg(lks_pkg::KEY_OFS, d);
      cmp(d, 32'h0000_0000);
      idle(2);
      cmp(line, 1'b1);
      rreg(8'h0C, d);
      cmp(d, 32'h0000_0000);
      conclude();
   end
endmodule : lks_ctrl_tb_top

// File: lks_host_model.sv
// Partner: host controller side, key matrix and pulled-up request line
module lks_host_model #(
   parameter int FRAME_CYC = 40
) (
   // Clock
   input wire logic clk,
   // Bench commands
   input wire logic frame_go,
   input wire logic hold_enable,
   input wire logic [29:0] keys_down,
   // Device pins
   input wire logic [5:0] scan_outputs,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_n,
   output logic transfer_enable,
   output logic [4:0] return_inputs,
   output logic serial_line
);
   int frame_cnt = 0;
   // Pull-up: a released line reads high, and key data is only trusted while it is low
   assign serial_line = serial_out_oe_n ? 1'b1 : serial_out_o;
   // A closed key ties its scan line to its return input
   always_comb begin
      return_inputs = 5'h00;
      for (int l = 0; l < 6; l++) begin
         for (int i = 0; i < 5; i++) begin
            if (scan_outputs[l] && keys_down[l * 5 + i]) begin
               return_inputs[i] = 1'b1;
            end
         end
      end
   end
   // One frame stands for all display plus control data; its falling edge ends it
   always @(posedge clk) begin
      if (frame_go) begin
         frame_cnt <= FRAME_CYC;
      end else if (frame_cnt > 0) begin
         frame_cnt <= frame_cnt - 1;
      end
   end
   assign transfer_enable = hold_enable || (frame_cnt > 0);
endmodule : lks_host_model

// File: lks_pkg.sv
// Package: constants, control layout and timing of the key scan and sleep/reset control block
package lks_pkg;

   // ****************************************
   // Register map (byte offsets)
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] KEY_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_W = 17;
   localparam int KEY_SLEEP_ACK_POS = 30;
   localparam int STAT_SYS_RST_POS = 0;
   localparam int STAT_REQ_POS = 1;
   localparam int STAT_BAD_FRAME_POS = 2;
   localparam int STAT_SCANNING_POS = 3;

   // ****************************************
   // Control word
   // ****************************************
   typedef struct packed {
      logic [3:0] port_data;
      logic duty_select_bit;
      logic [2:0] frame_rate_bits;
      logic scan_disable_bit;
      logic [2:0] scan_line_level_bits;
      logic [2:0] port_function_bits;
      logic clock_source_select;
      logic sleep_select;
   } lks_ctrl_t;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h00000;

   // ****************************************
   // Key matrix
   // ****************************************
   localparam int SCAN_LINES = 6;
   localparam int RETURN_LINES = 5;
   localparam int KEY_BITS = 30;
   localparam int SHARED_PINS = 4;

   // ****************************************
   // Timing, in oscillator periods T
   // ****************************************
   localparam int SCAN_PASS_T = 288;
   localparam int SLOT_T = SCAN_PASS_T / SCAN_LINES;
   localparam int REQUEST_T = 615;
   localparam logic [9:0] DIV_768 = 10'h300;
   localparam logic [9:0] DIV_576 = 10'h240;
   localparam logic [9:0] DIV_384 = 10'h180;
   localparam logic [9:0] DIV_288 = 10'h120;
   localparam logic [9:0] DIV_192 = 10'h0C0;

   // Internal RC oscillator nominal period against the 250 MHz system clock
   localparam int CLK_PERIOD_PS = 4000;
   localparam int OSC_PERIOD_PS = 26316000;
   localparam int OSC_DIV_DEF = OSC_PERIOD_PS / CLK_PERIOD_PS;

   // ****************************************
   // Synchronised pin vector
   // ****************************************
   localparam int PIN_W = 8;
   localparam int PIN_CE = 0;
   localparam int PIN_SUPPLY_DETECT_RESET = 1;
   localparam int PIN_EXTCLK = 2;
   localparam int PIN_RET = 3;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PASS1,
      ST_PASS2,
      ST_SETTLE,
      ST_REQUEST
   } lks_state_t;

endpackage : lks_pkg
